// ### design/pulse_divider.sv
`timescale 1ns/100ps
module pulse_divider #(
  parameter int DIV = 250
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Count enable and one-cycle output pulse
  input wire logic enable,
  output logic pulse
);

  // Divider must count at least one cycle
  if (DIV < 1) begin : gDivCheck
    $error("pulse_divider: DIV must be at least 1");
  end

  localparam logic [31:0] LAST = 32'(DIV - 1);

  logic [31:0] count_q; // Cycles since last pulse
  logic [31:0] count_d;
  logic pulse_q; // Registered pulse
  logic pulse_d;

  // Next values: wrap at LAST and strobe once per wrap
  always_comb begin
    count_d = count_q;
    pulse_d = 1'b0;
    if (enable) begin
      if (count_q >= LAST) begin
        count_d = 32'h0000_0000;
        pulse_d = 1'b1;
      end else begin
        count_d = count_q + 32'h0000_0001;
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 32'h0000_0000;
      pulse_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule

// ### design/rtc_flag_write_control.sv
`timescale 1ns/100ps
module rtc_flag_write_control #(
  parameter int OSC_CHECK_CYCLES_P = rtc_flag_pkg::OSC_CHECK_CYCLES,
  parameter int SEC_TICK_CYCLES_P = rtc_flag_pkg::SEC_TICK_CYCLES,
  parameter int XFER_CYCLES_P = rtc_flag_pkg::XFER_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [rtc_flag_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rtc_flag_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [rtc_flag_pkg::BE_W-1:0] avs_byteenable,
  output logic [rtc_flag_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Oscillator and nonvolatile flag pins
  input wire logic oscEnabled,
  input wire logic oscRunning,
  input wire logic nvClockStopIn,
  output logic nvClockStopOut,
  // Interrupt
  output logic irq
);

  import rtc_flag_pkg::*;

  // Counts the logic cannot serve
  if (OSC_CHECK_CYCLES_P < 1 || SEC_TICK_CYCLES_P < 1 || XFER_CYCLES_P < 1) begin : gParamCheck
    $error("rtc_flag_write_control: cycle counts must be at least 1");
  end

  localparam logic [31:0] CHECK_LAST = 32'(OSC_CHECK_CYCLES_P - 1);
  localparam logic [31:0] XFER_LAST = 32'(XFER_CYCLES_P - 1);

  // Address decode, shared by read mux and write path
  function automatic reg_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    case (addr)
      OFS_FLAGS: sel = SEL_FLAGS;
      OFS_TIME: sel = SEL_TIME;
      OFS_ALARM: sel = SEL_ALARM;
      OFS_ALARM_EN: sel = SEL_ALARM_EN;
      OFS_IRQ_STAT: sel = SEL_IRQ_STAT;
      OFS_IRQ_CLR: sel = SEL_IRQ_CLR;
      OFS_IRQ_EN: sel = SEL_IRQ_EN;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // Byte-lane merge of write data into an old word
  function automatic logic [DATA_W-1:0] laneMerge(input logic [DATA_W-1:0] oldVal,
                                                  input logic [DATA_W-1:0] newVal,
                                                  input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] res;
    res = oldVal;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Synchronised pin levels
  logic oscEnabledSync;
  logic oscRunningSync;
  logic nvClockStopSync;

  // One-second tick
  logic secTick;

  // Bus slave state
  logic waitReq_q; // Low for exactly the accept cycle
  logic waitReq_d;
  logic [DATA_W-1:0] readData_q; // Captured one cycle before accept
  logic [DATA_W-1:0] readData_d;

  // Flags register bits
  logic freeze_q; // Host update-freeze bit
  logic freeze_d;
  logic snapshot_q; // Host snapshot latch bit
  logic snapshot_d;
  logic clockStop_q; // Oscillator failure flag
  logic clockStop_d;
  logic alarmMatch_q; // Alarm match flag
  logic alarmMatch_d;

  // Timekeeping
  logic [31:0] counter_q; // Internal running seconds counter
  logic [31:0] counter_d;
  logic [31:0] timeReg_q; // Visible timekeeping register
  logic [31:0] timeReg_d;
  logic timeChanged_q; // Host wrote time while frozen
  logic timeChanged_d;
  logic [31:0] alarm_q; // Alarm compare value
  logic [31:0] alarm_d;
  logic alarmEn_q; // Alarm compare enable
  logic alarmEn_d;

  // Transfer sequencer
  xfer_state_t xferState_q;
  xfer_state_t xferState_d;
  logic [31:0] xferCount_q;
  logic [31:0] xferCount_d;

  // Power-up check
  check_state_t checkState_q;
  check_state_t checkState_d;
  logic [31:0] checkCount_q;
  logic [31:0] checkCount_d;
  logic oscSeen_q; // Oscillator seen running in window
  logic oscSeen_d;

  // Interrupts
  logic [IRQ_W-1:0] irqStat_q;
  logic [IRQ_W-1:0] irqStat_d;
  logic [IRQ_W-1:0] irqEn_q;
  logic [IRQ_W-1:0] irqEn_d;
  logic irq_q;
  logic irq_d;

  // Pin synchronisers
  sync_two_flop uSyncOscEn (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(oscEnabled),
    .syncOut(oscEnabledSync)
  );

  sync_two_flop uSyncOscRun (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(oscRunning),
    .syncOut(oscRunningSync)
  );

  sync_two_flop uSyncNv (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(nvClockStopIn),
    .syncOut(nvClockStopSync)
  );

  // Seconds tick from the core clock
  pulse_divider #(
    .DIV(SEC_TICK_CYCLES_P)
  ) uSecDiv (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(1'b1),
    .pulse(secTick)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic req;
    logic accept;
    logic wrHit;
    logic rdHit;
    reg_sel_t sel;
    logic [DATA_W-1:0] rdVal;
    logic [DATA_W-1:0] wrWord;
    logic [IRQ_W-1:0] events;
    logic [31:0] nextCount;
    logic loadDone;
    req = avs_read | avs_write;
    accept = req & ~waitReq_q;
    sel = decodeSel(avs_address);
    wrHit = accept & avs_write;
    rdHit = accept & avs_read;
    rdVal = 32'h0000_0000;
    wrWord = 32'h0000_0000;
    events = IRQ_RESET;
    nextCount = counter_q + 32'h0000_0001;
    loadDone = 1'b0;

    waitReq_d = ~(req & waitReq_q);
    readData_d = readData_q;
    freeze_d = freeze_q;
    snapshot_d = snapshot_q;
    clockStop_d = clockStop_q;
    alarmMatch_d = alarmMatch_q;
    counter_d = counter_q;
    timeReg_d = timeReg_q;
    timeChanged_d = timeChanged_q;
    alarm_d = alarm_q;
    alarmEn_d = alarmEn_q;
    xferState_d = xferState_q;
    xferCount_d = xferCount_q;
    checkState_d = checkState_q;
    checkCount_d = checkCount_q;
    oscSeen_d = oscSeen_q;
    irqStat_d = irqStat_q;
    irqEn_d = irqEn_q;

    // Read mux; reserved and write-only locations read zero
    case (sel)
      SEL_FLAGS: begin
        rdVal[BIT_SNAPSHOT] = snapshot_q;
        rdVal[BIT_FREEZE] = freeze_q;
        rdVal[BIT_CLOCK_STOP] = clockStop_q;
        rdVal[BIT_ALARM_MATCH] = alarmMatch_q;
      end
      SEL_TIME: rdVal = timeReg_q;
      SEL_ALARM: rdVal = alarm_q;
      SEL_ALARM_EN: rdVal[0] = alarmEn_q;
      SEL_IRQ_STAT: rdVal[IRQ_W-1:0] = irqStat_q;
      SEL_IRQ_EN: rdVal[IRQ_W-1:0] = irqEn_q;
      default: rdVal = 32'h0000_0000;
    endcase
    // Capture in the waiting cycle so data stands at the accept edge
    if (req && waitReq_q) begin
      readData_d = rdVal;
    end

    // Running counter; a pending load takes over the tick
    if (secTick) begin
      counter_d = nextCount;
      if (alarmEn_q && nextCount == alarm_q) begin
        events[IRQ_ALARM] = 1'b1;
      end
    end

    // Counter transfer after freeze release
    case (xferState_q)
      XF_IDLE: begin
        xferCount_d = 32'h0000_0000;
      end
      XF_BUSY: begin
        if (xferCount_q >= XFER_LAST) begin
          counter_d = timeReg_q;
          loadDone = 1'b1;
          xferState_d = XF_IDLE;
        end else begin
          xferCount_d = xferCount_q + 32'h0000_0001;
        end
      end
      default: begin
        xferState_d = XF_IDLE;
      end
    endcase
    events[IRQ_XFER_DONE] = loadDone;

    // Visible register follows the counter unless frozen, latched or a counter transfer is in progress
    if (!freeze_q && !snapshot_q && xferState_q == XF_IDLE) begin
      timeReg_d = counter_q;
    end

    // Power-up oscillator check window
    case (checkState_q)
      CHK_WAIT: begin
        if (oscRunningSync) begin
          oscSeen_d = 1'b1;
        end
        if (checkCount_q >= CHECK_LAST) begin
          checkState_d = CHK_DONE;
          // Stored flag restored, failure adds to it
          if (nvClockStopSync || (oscEnabledSync && !(oscSeen_q || oscRunningSync))) begin
            events[IRQ_CLOCK_STOP] = 1'b1;
          end
        end else begin
          checkCount_d = checkCount_q + 32'h0000_0001;
        end
      end
      CHK_DONE: begin
        checkCount_d = checkCount_q;
      end
      default: begin
        checkState_d = CHK_DONE;
      end
    endcase

    // Register writes
    if (wrHit) begin
      wrWord = laneMerge(32'h0000_0000, avs_writedata, avs_byteenable);
      case (sel)
        SEL_FLAGS: begin
          if (avs_byteenable[0]) begin
            snapshot_d = wrWord[BIT_SNAPSHOT];
            freeze_d = wrWord[BIT_FREEZE];
            if (!wrWord[BIT_CLOCK_STOP]) begin
              clockStop_d = 1'b0;
            end
            // Falling freeze with changed time starts the load
            if (freeze_q && !wrWord[BIT_FREEZE] && timeChanged_q) begin
              xferState_d = XF_BUSY;
              timeChanged_d = 1'b0;
            end else if (freeze_q && !wrWord[BIT_FREEZE]) begin
              timeChanged_d = 1'b0;
            end
          end
        end
        SEL_TIME: begin
          // Writes only land while frozen
          if (freeze_q) begin
            timeReg_d = laneMerge(timeReg_q, avs_writedata, avs_byteenable);
            timeChanged_d = 1'b1;
          end
        end
        SEL_ALARM: alarm_d = laneMerge(alarm_q, avs_writedata, avs_byteenable);
        SEL_ALARM_EN: begin
          if (avs_byteenable[0]) begin
            alarmEn_d = avs_writedata[0];
          end
        end
        SEL_IRQ_CLR: begin
          if (avs_byteenable[0]) begin
            irqStat_d = irqStat_q & ~avs_writedata[IRQ_W-1:0];
          end
        end
        SEL_IRQ_EN: begin
          if (avs_byteenable[0]) begin
            irqEn_d = avs_writedata[IRQ_W-1:0];
          end
        end
        default: begin
          irqEn_d = irqEn_q;
        end
      endcase
    end

    // Read of flags clears only an alarm flag the host has seen
    if (rdHit && sel == SEL_FLAGS && readData_q[BIT_ALARM_MATCH]) begin
      alarmMatch_d = 1'b0;
    end

    // Hardware sets win over software clears
    if (events[IRQ_ALARM]) begin
      alarmMatch_d = 1'b1;
    end
    if (events[IRQ_CLOCK_STOP]) begin
      clockStop_d = 1'b1;
    end
    irqStat_d = irqStat_d | events;
    irq_d = |(irqStat_d & irqEn_d);
  end

  // Registers; power-up values double as reset values
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitReq_q <= 1'b1;
      readData_q <= 32'h0000_0000;
      freeze_q <= 1'b0;
      snapshot_q <= 1'b0;
      clockStop_q <= 1'b0;
      alarmMatch_q <= 1'b0;
      counter_q <= TIME_RESET;
      timeReg_q <= TIME_RESET;
      timeChanged_q <= 1'b0;
      alarm_q <= ALARM_RESET;
      alarmEn_q <= 1'b0;
      xferState_q <= XF_IDLE;
      xferCount_q <= 32'h0000_0000;
      checkState_q <= CHK_WAIT;
      checkCount_q <= 32'h0000_0000;
      oscSeen_q <= 1'b0;
      irqStat_q <= IRQ_RESET;
      irqEn_q <= IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      waitReq_q <= waitReq_d;
      readData_q <= readData_d;
      freeze_q <= freeze_d;
      snapshot_q <= snapshot_d;
      clockStop_q <= clockStop_d;
      alarmMatch_q <= alarmMatch_d;
      counter_q <= counter_d;
      timeReg_q <= timeReg_d;
      timeChanged_q <= timeChanged_d;
      alarm_q <= alarm_d;
      alarmEn_q <= alarmEn_d;
      xferState_q <= xferState_d;
      xferCount_q <= xferCount_d;
      checkState_q <= checkState_d;
      checkCount_q <= checkCount_d;
      oscSeen_q <= oscSeen_d;
      irqStat_q <= irqStat_d;
      irqEn_q <= irqEn_d;
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flops
  assign avs_readdata = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign nvClockStopOut = clockStop_q;
  assign irq = irq_q;

endmodule

// ### design/sync_two_flop.sv
`timescale 1ns/100ps
module sync_two_flop (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Asynchronous level in, synchronised level out
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_q; // First stage, read only by the second stage
  logic meta_d;
  logic sync_q; // Second stage
  logic sync_d;

  // Next values: plain shift
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // Registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule

// ### pkg/rtc_flag_pkg.sv
package rtc_flag_pkg;

  // Core clock rate
  localparam int CLK_FREQ_MHZ = 250;

  // Power-up oscillator check window
  localparam int OSC_CHECK_TIME_MS = 5;
  localparam int OSC_CHECK_CYCLES = OSC_CHECK_TIME_MS * 1000 * CLK_FREQ_MHZ;

  // Counter transfer time; longest time, so the cycle count rounds down
  localparam int XFER_TIME_NS = 1000;
  localparam int XFER_CYCLES_RAW = (XFER_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int XFER_CYCLES = (XFER_CYCLES_RAW < 1) ? 1 : XFER_CYCLES_RAW;

  // One-second timekeeping tick
  localparam int SEC_TICK_TIME_MS = 1000;
  localparam int SEC_TICK_CYCLES = SEC_TICK_TIME_MS * 1000 * CLK_FREQ_MHZ;

  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Register byte offsets
  localparam logic [4:0] OFS_FLAGS = 5'h00;
  localparam logic [4:0] OFS_TIME = 5'h04;
  localparam logic [4:0] OFS_ALARM = 5'h08;
  localparam logic [4:0] OFS_ALARM_EN = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
  localparam logic [4:0] OFS_IRQ_EN = 5'h18;

  // Flags register field positions
  localparam int BIT_SNAPSHOT = 0;
  localparam int BIT_FREEZE = 1;
  localparam int BIT_CLOCK_STOP = 4;
  localparam int BIT_ALARM_MATCH = 6;
  localparam int FLAGS_W = 8;

  // Interrupt status, clear and enable layout
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_CLOCK_STOP = 1;
  localparam int IRQ_XFER_DONE = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
  localparam logic [31:0] ALARM_RESET = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Register select codes
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_FLAGS = 3'h1,
    SEL_TIME = 3'h2,
    SEL_ALARM = 3'h3,
    SEL_ALARM_EN = 3'h4,
    SEL_IRQ_STAT = 3'h5,
    SEL_IRQ_CLR = 3'h6,
    SEL_IRQ_EN = 3'h7
  } reg_sel_t;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    XF_IDLE = 2'b01,
    XF_BUSY = 2'b10
  } xfer_state_t;

  // Power-up oscillator check states
  typedef enum logic [1:0] {
    CHK_WAIT = 2'b01,
    CHK_DONE = 2'b10
  } check_state_t;

endpackage

// ### testbench/host_bus_master.sv
`timescale 1ns/100ps
module host_bus_master #(
  parameter int XFER_P = 4
) (
  // Clock
  input wire logic core_clk,
  // Avalon-MM master side
  output logic [rtc_flag_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [rtc_flag_pkg::DATA_W-1:0] avs_writedata,
  output logic [rtc_flag_pkg::BE_W-1:0] avs_byteenable,
  input wire logic [rtc_flag_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  import rtc_flag_pkg::*;
  // Requests that never got an answer
  int hangs = 0;
  assign avs_byteenable = '1;
  // Idle bus from time zero
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end
  // One request held until waitrequest is sampled low
  task automatic busCycle(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    q = 'x;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest === 1'b0) q = avs_readdata;
    else hangs++;
    // Released lines show garbage, not the last value
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] unused;
    busCycle(1'b1, a, d, unused);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
    busCycle(1'b0, a, '0, q);
  endtask
  // Freeze first so the write cannot race the running counters
  task automatic freezeWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr(OFS_FLAGS, 32'h1 << BIT_FREEZE);
    wr(a, d);
  endtask
  // New time is not trusted before the transfer time runs out
  task automatic thaw();
    wr(OFS_FLAGS, 32'h0);
    repeat (XFER_P + 2) @(posedge core_clk);
  endtask
  // Writing zero acknowledges the lost-power condition
  task automatic clearStop();
    wr(OFS_FLAGS, 32'h0);
  endtask
endmodule

// ### testbench/rtc_flag_write_control_properties.sv
`timescale 1ns/100ps
module rtc_flag_checker #(
  parameter int OSC_P = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [rtc_flag_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rtc_flag_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [rtc_flag_pkg::BE_W-1:0] avs_byteenable,
  input wire logic [rtc_flag_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Flag and interrupt outputs
  input wire logic nvClockStopOut,
  input wire logic irq
);
  import rtc_flag_pkg::*;
  // Edges since reset release; saturates so it never wraps
  int upCnt_q;
  int upCnt_d;
  logic rdAcc;
  logic stopClr;
  // Accepted read, and an accepted write of zero to the stop bit
  assign rdAcc = avs_read && !avs_waitrequest;
  assign stopClr = avs_write && !avs_waitrequest && avs_address == OFS_FLAGS &&
                   avs_byteenable[0] && !avs_writedata[BIT_CLOCK_STOP];
  // Next count
  always_comb begin
    upCnt_d = (upCnt_q < 100000) ? upCnt_q + 1 : upCnt_q;
  end
  // Count register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upCnt_q <= 0;
    end else begin
      upCnt_q <= upCnt_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_ANSWER: assert property ($rose(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  AST_WAIT_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without a request");
  AST_RD_ZERO: assert property (rdAcc && (avs_address[1:0] != 2'h0 || avs_address >= 5'h1c ||
    avs_address == OFS_IRQ_CLR) |-> avs_readdata == '0)
    else $error("unmapped or write-only place reads nonzero");
  AST_FLAGS_SPARE: assert property (rdAcc && avs_address == OFS_FLAGS |-> (avs_readdata & ~32'h53) == '0)
    else $error("unused flag bits read nonzero");
  AST_STOP_WINDOW: assert property ($rose(nvClockStopOut) |-> upCnt_q >= OSC_P - 2 && upCnt_q <= OSC_P + 6)
    else $error("stop flag set outside the check window");
  AST_STOP_CLEAR: assert property ($fell(nvClockStopOut) |-> $past(stopClr) || $past(stopClr, 2))
    else $error("stop flag cleared without a host write");
  AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_waitrequest && (avs_read || avs_write)))
    else $error("read data changed outside a waiting cycle");
  COV_FLAGS_READ: cover property (rdAcc && avs_address == OFS_FLAGS);
  COV_STOP_SET: cover property ($rose(nvClockStopOut));
  COV_IRQ: cover property ($rose(irq));
endmodule
bind rtc_flag_write_control rtc_flag_checker #(.OSC_P(OSC_CHECK_CYCLES_P)) chkI (.core_clk(core_clk),
  .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .nvClockStopOut(nvClockStopOut), .irq(irq));

// ### testbench/test_rtc_flag_write_control.sv
`timescale 1ns/100ps
module test_rtc_flag_write_control;
  import rtc_flag_pkg::*;
  // Shortened counts keep the run brief
  localparam int OSC_P = 20;
  localparam int XFER_P = 4;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic oscEnabled = 1'b1;
  logic oscRunning = 1'b1;
  logic nvClockStopIn = 1'b0;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [BE_W-1:0] avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic nvClockStopOut;
  logic irq;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  int nMismatch = 0;
  int testsRun = 0;
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  rtc_flag_write_control #(.OSC_CHECK_CYCLES_P(OSC_P), .SEC_TICK_CYCLES_P(10), .XFER_CYCLES_P(XFER_P)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .oscEnabled(oscEnabled),
    .oscRunning(oscRunning), .nvClockStopIn(nvClockStopIn), .nvClockStopOut(nvClockStopOut), .irq(irq));
  host_bus_master #(.XFER_P(XFER_P)) host (.core_clk(core_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task automatic fail(input string m);
    nMismatch++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    testsRun++;
    if (got !== exp) fail($sformatf("got %h want %h", got, exp));
  endtask
  task automatic chkIn(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
    testsRun++;
    if ((got >= lo && got <= hi) !== 1'b1) fail($sformatf("got %h outside %h..%h", got, lo, hi));
  endtask
  // Power cycle with the given pin levels, then let the check window end
  task automatic resetDut(input logic en, input logic run, input logic nvIn);
    sys_rst <= 1'b1;
    oscEnabled <= en;
    oscRunning <= run;
    nvClockStopIn <= nvIn;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (OSC_P + 10) @(posedge core_clk);
  endtask
  // Clean power-up, spare and write-only places read zero
  task automatic testPowerUp();
    logic [ADDR_W-1:0] zeroAt [5];
    zeroAt = '{5'h1c, OFS_IRQ_CLR, 5'h01, OFS_IRQ_EN, OFS_IRQ_STAT};
    host.rd(OFS_FLAGS, q);
    chk(q, 32'h0);
    chk({31'h0, nvClockStopOut}, 32'h0);
    foreach (zeroAt[i]) begin
      host.rd(zeroAt[i], q);
      chk(q, 32'h0);
    end
  endtask
  // Frozen time holds, new time loads after release
  task automatic testFreeze();
    host.wr(OFS_IRQ_CLR, 32'h7);
    host.wr(OFS_FLAGS, 32'h2);
    host.rd(OFS_TIME, a);
    repeat (25) @(posedge core_clk);
    host.rd(OFS_TIME, b);
    chk(b, a);
    host.wr(OFS_TIME, 32'h100);
    host.rd(OFS_TIME, q);
    chk(q, 32'h100);
    host.thaw();
    host.rd(OFS_TIME, q);
    chkIn(q, 32'h100, 32'h101);
    host.rd(OFS_IRQ_STAT, q);
    chk(q & 32'h4, 32'h4);
  endtask
  // Release without a change loads nothing; unfrozen time writes are ignored
  task automatic testNoChange();
    host.wr(OFS_IRQ_CLR, 32'h7);
    host.wr(OFS_FLAGS, 32'h2);
    host.thaw();
    host.rd(OFS_IRQ_STAT, q);
    chk(q & 32'h4, 32'h0);
    host.rd(OFS_TIME, a);
    host.wr(OFS_TIME, a + 32'h50);
    host.rd(OFS_TIME, b);
    chkIn(b, a, a + 32'h1);
    repeat (25) @(posedge core_clk);
    host.rd(OFS_TIME, b);
    chkIn(b, a + 32'h3, a + 32'h4);
  endtask
  // Snapshot holds the visible value while counting goes on
  task automatic testSnapshot();
    host.wr(OFS_FLAGS, 32'h1);
    host.rd(OFS_TIME, a);
    repeat (25) @(posedge core_clk);
    host.rd(OFS_TIME, b);
    chk(b, a);
    host.wr(OFS_FLAGS, 32'h0);
    repeat (25) @(posedge core_clk);
    host.rd(OFS_TIME, b);
    chkIn(b, a + 32'h5, a + 32'h7);
  endtask
  // Alarm match raises the flag and the interrupt; mask and clear
  task automatic testAlarm();
    int n;
    n = 0;
    host.wr(OFS_IRQ_CLR, 32'h7);
    host.rd(OFS_TIME, a);
    host.freezeWrite(OFS_ALARM, a + 32'h6);
    host.wr(OFS_ALARM_EN, 32'h1);
    host.wr(OFS_IRQ_EN, 32'h1);
    host.thaw();
    while (irq !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h40, 32'h40);
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h40, 32'h0);
    host.wr(OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    host.wr(OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    host.wr(OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    host.wr(OFS_ALARM_EN, 32'h0);
  endtask
  // Dead oscillator sets the flag; only a host zero clears it; it survives power cycles
  task automatic testClockStop();
    resetDut(1'b1, 1'b0, 1'b0);
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h10, 32'h10);
    chk({31'h0, nvClockStopOut}, 32'h1);
    oscRunning <= 1'b1;
    host.wr(OFS_FLAGS, 32'h10);
    repeat (30) @(posedge core_clk);
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h10, 32'h10);
    host.clearStop();
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h10, 32'h0);
    chk({31'h0, nvClockStopOut}, 32'h0);
    resetDut(1'b0, 1'b0, 1'b0);
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h10, 32'h0);
    resetDut(1'b1, 1'b1, 1'b1);
    host.rd(OFS_FLAGS, q);
    chk(q & 32'h10, 32'h10);
  endtask
  task automatic giveVerdict();
    nMismatch += host.hangs;
    if (nMismatch == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    resetDut(1'b1, 1'b1, 1'b0);
    testPowerUp();
    testFreeze();
    testNoChange();
    testSnapshot();
    testAlarm();
    testClockStop();
    giveVerdict();
  end
  // Watchdog, well beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail("watchdog");
    giveVerdict();
  end
endmodule
